/* File: logic/sbcrm_pkg.sv */
// Package: mode codes, status encodings and timing constants for the restart/fail-safe sequencer
package sbcrm_pkg;
  typedef enum logic [6:0] {
    SBCRM_INIT    = 7'h01,
    SBCRM_NORMAL  = 7'h02,
    SBCRM_STOP    = 7'h04,
    SBCRM_SLEEP   = 7'h08,
    SBCRM_RESTART = 7'h10,
    SBCRM_FAILSAFE= 7'h20,
    SBCRM_FSWAIT  = 7'h40
  } sbcrm_mode_t;

  localparam logic [1:0] STAT_NONE    = 2'h0;
  localparam logic [1:0] STAT_FAULT   = 2'h1;
  localparam logic [1:0] STAT_SLEEPWK = 2'h2;
  localparam logic [1:0] WDF_ONE      = 2'h1;
  localparam logic [1:0] WDF_TWO      = 2'h2;
  localparam logic [2:0] WD_PERIOD_DEFAULT = 3'h4;
  localparam logic [2:0] UV_FS_COUNT       = 3'h4;

  localparam int CLK_MHZ          = 250;
  localparam int RESET_DELAY_US   = 10;
  localparam int FS_FILTER_MS     = 100;
  localparam int THERMAL_REC_MS   = 1000;
  localparam int TEST_TIME_US     = 100;
  localparam int RESET_DELAY_CYC  = RESET_DELAY_US * CLK_MHZ;
  localparam int FS_FILTER_CYC    = FS_FILTER_MS * 1000 * CLK_MHZ;
  localparam int THERMAL_REC_CYC  = THERMAL_REC_MS * 1000 * CLK_MHZ;
  localparam int TEST_TIME_CYC    = TEST_TIME_US * CLK_MHZ;
endpackage

/* File: logic/sbcrm_timer.sv */
// Down counter that flags when a loaded interval has run out
`timescale 1ns/1ps
module sbcrm_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             ref_clk,   // Clock
  input  wire logic             rst,       // Async reset
  input  wire logic             start,     // Load count
  input  wire logic             stop,      // Abandon count
  input  wire logic [WIDTH-1:0] loadVal,   // Cycles to run
  output logic                  expired    // Interval over, level
);
  logic [WIDTH-1:0] cnt_q;
  logic             run_q;

  initial begin
    if (WIDTH < 2) $error("sbcrm_timer: WIDTH too small");
  end

  // Count down while running
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= loadVal;
      run_q <= 1'b1;
    end else if (stop) begin
      run_q <= 1'b0;
    end else if (run_q && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = run_q && (cnt_q == '0);
endmodule // sbcrm_timer

/* File: logic/sbcrm_core.sv */
// Mode sequencer for restart, fail-safe and development modes
`timescale 1ns/1ps
module sbcrm_core #(
  parameter int RESET_DELAY  = sbcrm_pkg::RESET_DELAY_CYC,
  parameter int FS_FILTER    = sbcrm_pkg::FS_FILTER_CYC,
  parameter int THERMAL_REC  = sbcrm_pkg::THERMAL_REC_CYC,
  parameter int TEST_TIME    = sbcrm_pkg::TEST_TIME_CYC
) (
  input  wire logic       ref_clk,                  // 250 MHz clock
  input  wire logic       rst,                      // Power-on reset, async high
  input  wire logic       spiCmd,                   // SPI frame received, pulse
  input  wire logic       sleepReq,                 // Sleep mode requested, pulse
  input  wire logic       stopReq,                  // Stop mode requested, pulse
  input  wire logic       normalReq,                // Normal mode requested, pulse
  input  wire logic [1:0] configSel,                // Configuration 1..4 as 0..3
  input  wire logic       overvoltage_reset_enable, // Overvoltage reset enable bit
  input  wire logic       config_pin_select,        // Config pin select
  input  wire logic       wake_pin_measure_select,  // Wake pins 1,2 measuring
  input  wire logic       mainUv,                   // Main regulator undervoltage, pulse
  input  wire logic       mainOv,                   // Main regulator overvoltage, pulse
  input  wire logic       mainShort,                // Main regulator short, pulse
  input  wire logic       supplyAboveUv,            // Supply above its UV threshold
  input  wire logic       thermal_shutdown_level2,  // Thermal shutdown, pulse
  input  wire logic       wdFail,                   // Incorrect watchdog trigger, pulse
  input  wire logic       wakeEvent,                // Wake on default source, pulse
  input  wire logic       wakeFlagsPending,         // Uncleared wake status flags
  input  wire logic       canActive,                // CAN was normal/RX-only/wake
  input  wire logic       linActive,                // LIN was normal/RX-only/wake
  input  wire logic       test_strap_pin,           // Test strap level
  input  wire logic       statusClear,              // Clear status fields, pulse
  output logic [6:0]      modeState,                // Current mode, one-hot
  output logic            reset_output,             // Reset to controller, low active
  output logic            fail_outputs,             // Fail outputs active, high
  output logic            mainRegOn,                // Main regulator enabled
  output logic            secondRegOff,             // Force second regulator off
  output logic            highSideOff,              // Force high-side outputs off
  output logic            canWakeCap,               // CAN set wake capable
  output logic            linWakeCap,               // LIN set wake capable
  output logic            defaultWakeEn,            // Default wake sources enabled
  output logic            wakePinsMeasure,          // Wake pins 1,2 stay measuring
  output logic            wakeFlagsClear,           // Clear wake status first, pulse
  output logic            cyclicDisable,            // Cyclic sense/wake disabled
  output logic            spiIgnore,                // SPI not interpreted
  output logic            modeBitsClear,            // Clear mode selection bits, pulse
  output logic            wdLongWindow,             // Start long open window, pulse
  output logic            wdPeriodLoad,             // Force watchdog period, pulse
  output logic [2:0]      wdPeriodVal,              // Forced period value
  output logic            devModeDefaultsOn,        // LIN, CAN, SECOND_REGULATOR default on
  output logic            devMode,                  // Development mode latched
  output logic [1:0]      device_status_field,      // Device status field
  output logic [1:0]      watchdog_fail_field,      // Watchdog fail field
  output logic            failureFlag,              // Failure flag
  output logic            thermalFlag,              // Thermal shutdown flag
  output logic            main_supply_undervoltage_flag, // Undervoltage flag
  output logic            undervoltage_failsafe_flag,    // Four-UV fail-safe flag
  output logic            main_supply_overvoltage_flag,  // Overvoltage flag
  output logic            main_supply_short_flag         // Short flag
);
  typedef sbcrm_pkg::sbcrm_mode_t sbcrm_state_t;

  sbcrm_state_t mode_q, mode_d;
  logic        dev_q, testHigh_q, fo_q, thermFs_q, wakeLatch_q, fromSleep_q;
  logic [1:0]  wdCnt_q, stat_q;
  logic [2:0]  uvCnt_q;
  logic [31:0] testCnt_q;
  logic        fTherm_q, fUv_q, fUvFs_q, fOv_q, fSc_q, fFail_q;
  logic        rstTimerDone, fsTimerDone, thTimerDone;
  logic        inRestart, inFs, wdEff, uvCnt4;
  logic        goFs, goRestart, wdToFs, wdToRestart, ovToFs, ovToRestart;
  logic        foSet;
  logic [1:0]  wdNext;

  initial begin
    if (RESET_DELAY < 1 || FS_FILTER < 1 || THERMAL_REC < 1 || TEST_TIME < 1)
      $error("sbcrm_core: timing parameters must be at least one cycle");
  end

  assign inRestart = (mode_q == sbcrm_pkg::SBCRM_RESTART);
  assign inFs      = (mode_q == sbcrm_pkg::SBCRM_FAILSAFE) || (mode_q == sbcrm_pkg::SBCRM_FSWAIT);
  // Watchdog failures count only outside development mode
  assign wdEff     = wdFail && !dev_q;
  assign wdNext    = (wdCnt_q == 2'h0) ? sbcrm_pkg::WDF_ONE : sbcrm_pkg::WDF_TWO;
  assign uvCnt4    = (uvCnt_q + 3'h1) >= sbcrm_pkg::UV_FS_COUNT;

  // Cause decoding, configuration 1..4 is configSel 0..3
  assign wdToFs      = wdEff && ((configSel == 2'h1) ||
                       (configSel == 2'h3 && wdCnt_q != 2'h0));
  assign wdToRestart = wdEff && !wdToFs;
  assign ovToRestart = mainOv && overvoltage_reset_enable && config_pin_select;
  assign ovToFs      = mainOv && overvoltage_reset_enable && !config_pin_select;
  assign goFs = thermal_shutdown_level2 || mainShort || ovToFs || wdToFs ||
                (mainUv && supplyAboveUv && uvCnt4);
  assign goRestart = mainUv || ovToRestart || wdToRestart;
  // Fail outputs set by listed causes
  assign foSet = (wdEff && wdCnt_q == 2'h0 && configSel[1] == 1'b0) ||
                 (mainOv && overvoltage_reset_enable) || goFs;

  // Mode transitions, fail-safe checked first
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      sbcrm_pkg::SBCRM_INIT: begin
        if (goFs) mode_d = sbcrm_pkg::SBCRM_FAILSAFE;
        else if (wdToRestart) mode_d = sbcrm_pkg::SBCRM_RESTART;
        else if (spiCmd) mode_d = sbcrm_pkg::SBCRM_NORMAL;
      end
      sbcrm_pkg::SBCRM_NORMAL, sbcrm_pkg::SBCRM_STOP: begin
        if (goFs) mode_d = sbcrm_pkg::SBCRM_FAILSAFE;
        else if (goRestart) mode_d = sbcrm_pkg::SBCRM_RESTART;
        else if (sleepReq && wakeFlagsPending) mode_d = sbcrm_pkg::SBCRM_RESTART;
        else if (sleepReq) mode_d = sbcrm_pkg::SBCRM_SLEEP;
        else if (stopReq) mode_d = sbcrm_pkg::SBCRM_STOP;
        else if (normalReq) mode_d = sbcrm_pkg::SBCRM_NORMAL;
      end
      sbcrm_pkg::SBCRM_SLEEP: begin
        if (goFs) mode_d = sbcrm_pkg::SBCRM_FAILSAFE;
        else if (wakeEvent) mode_d = sbcrm_pkg::SBCRM_RESTART;
      end
      sbcrm_pkg::SBCRM_RESTART: begin
        if (goFs) mode_d = sbcrm_pkg::SBCRM_FAILSAFE;
        else if (rstTimerDone) mode_d = sbcrm_pkg::SBCRM_NORMAL;
      end
      sbcrm_pkg::SBCRM_FAILSAFE: begin
        if (fsTimerDone) mode_d = sbcrm_pkg::SBCRM_FSWAIT;
      end
      sbcrm_pkg::SBCRM_FSWAIT: begin
        if (thermFs_q) begin
          if (thTimerDone) mode_d = sbcrm_pkg::SBCRM_RESTART;
        end else if (wakeLatch_q || wakeEvent) begin
          mode_d = sbcrm_pkg::SBCRM_RESTART;
        end
      end
      default: mode_d = sbcrm_pkg::SBCRM_INIT;
    endcase
  end

  // Mode register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) mode_q <= sbcrm_pkg::SBCRM_INIT;
    else     mode_q <= mode_d;
  end

  // Reset delay timer, starts on restart entry
  sbcrm_timer #(.WIDTH(32)) u_rstTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (mode_d == sbcrm_pkg::SBCRM_RESTART && !inRestart),
    .stop    (!inRestart),
    .loadVal (32'(RESET_DELAY - 1)),
    .expired (rstTimerDone)
  );

  // Fail-safe minimum filter timer
  sbcrm_timer #(.WIDTH(32)) u_fsTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (mode_d == sbcrm_pkg::SBCRM_FAILSAFE && !inFs),
    .stop    (!inFs),
    .loadVal (32'(FS_FILTER - 1)),
    .expired (fsTimerDone)
  );

  // Thermal recovery timer, runs from fail-safe entry
  sbcrm_timer #(.WIDTH(32)) u_thTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (mode_d == sbcrm_pkg::SBCRM_FAILSAFE && !inFs),
    .stop    (!inFs),
    .loadVal (32'(THERMAL_REC - 1)),
    .expired (thTimerDone)
  );

  // Fail-safe cause and latched wakes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thermFs_q   <= 1'b0;
      wakeLatch_q <= 1'b0;
    end else if (mode_d == sbcrm_pkg::SBCRM_FAILSAFE && !inFs) begin
      thermFs_q   <= thermal_shutdown_level2;
      wakeLatch_q <= 1'b0;
    end else if (inFs && wakeEvent) begin
      wakeLatch_q <= 1'b1;
    end
  end

  // Consecutive undervoltage counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) uvCnt_q <= 3'h0;
    else if (mode_q == sbcrm_pkg::SBCRM_NORMAL && !mainUv && mode_d == mode_q && spiCmd)
      uvCnt_q <= 3'h0;
    else if (mode_d == sbcrm_pkg::SBCRM_FAILSAFE && !inFs) uvCnt_q <= 3'h0;
    else if (mainUv && supplyAboveUv) uvCnt_q <= uvCnt_q + 3'h1;
  end

  // Watchdog failure count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) wdCnt_q <= 2'h0;
    else if (wdEff) wdCnt_q <= wdNext;
    else if (statusClear) wdCnt_q <= 2'h0;
  end

  // Fail outputs, sticky until power-on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) fo_q <= 1'b0;
    else if (foSet) fo_q <= 1'b1;
  end

  // Sleep origin for status encoding
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) fromSleep_q <= 1'b0;
    else if (mode_d == sbcrm_pkg::SBCRM_RESTART && !inRestart)
      fromSleep_q <= (mode_q == sbcrm_pkg::SBCRM_SLEEP) ||
                     (sleepReq && wakeFlagsPending);
  end

  // Device status field, set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) stat_q <= sbcrm_pkg::STAT_NONE;
    else if (mode_d == sbcrm_pkg::SBCRM_FAILSAFE && !inFs)
      stat_q <= sbcrm_pkg::STAT_FAULT;
    else if (inRestart && mode_d == sbcrm_pkg::SBCRM_NORMAL && !fFail_q)
      stat_q <= fromSleep_q ? sbcrm_pkg::STAT_SLEEPWK : sbcrm_pkg::STAT_FAULT;
    else if (statusClear) stat_q <= sbcrm_pkg::STAT_NONE;
  end

  // Cause flags, set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fTherm_q <= 1'b0;
      fUv_q    <= 1'b0;
      fUvFs_q  <= 1'b0;
      fOv_q    <= 1'b0;
      fSc_q    <= 1'b0;
      fFail_q  <= 1'b0;
    end else begin
      fTherm_q <= thermal_shutdown_level2 || (fTherm_q && !statusClear);
      fUv_q    <= mainUv || mainShort || (fUv_q && !statusClear);
      fUvFs_q  <= (mainUv && supplyAboveUv && uvCnt4) || (fUvFs_q && !statusClear);
      fOv_q    <= mainOv || (fOv_q && !statusClear);
      fSc_q    <= mainShort || (fSc_q && !statusClear);
      fFail_q  <= (goFs && !inFs) || (fFail_q && !statusClear);
    end
  end

  // Test strap monitoring during init
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      testCnt_q  <= 32'h0;
      testHigh_q <= 1'b0;
    end else if (mode_q == sbcrm_pkg::SBCRM_INIT) begin
      if (!test_strap_pin) testCnt_q <= 32'h0;
      else if (testCnt_q >= 32'(TEST_TIME)) testHigh_q <= 1'b1;
      else testCnt_q <= testCnt_q + 32'h1;
    end
  end

  // Development mode latch, only power-on clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) dev_q <= 1'b0;
    else if (mode_q == sbcrm_pkg::SBCRM_INIT && spiCmd && !test_strap_pin && !testHigh_q)
      dev_q <= 1'b1;
  end

  // Outputs
  assign modeState     = mode_q;
  assign reset_output  = !(inRestart || inFs || mode_q == sbcrm_pkg::SBCRM_SLEEP);
  assign fail_outputs  = fo_q || inFs;
  assign mainRegOn     = !inFs && mode_q != sbcrm_pkg::SBCRM_SLEEP;
  assign secondRegOff  = inRestart || inFs;
  assign highSideOff   = inRestart || inFs;
  assign canWakeCap    = (inRestart && canActive) || inFs;
  assign linWakeCap    = (inRestart && linActive) || inFs;
  assign defaultWakeEn = inFs;
  assign wakePinsMeasure = inFs && wake_pin_measure_select;
  assign wakeFlagsClear  = (mode_d == sbcrm_pkg::SBCRM_FAILSAFE) && !inFs;
  assign cyclicDisable   = inFs;
  assign spiIgnore       = inRestart || inFs;
  assign modeBitsClear   = inRestart && (mode_d == sbcrm_pkg::SBCRM_NORMAL);
  assign wdLongWindow    = modeBitsClear && !dev_q;
  assign wdPeriodLoad    = modeBitsClear;
  assign wdPeriodVal     = sbcrm_pkg::WD_PERIOD_DEFAULT;
  assign devModeDefaultsOn = dev_q;
  assign devMode         = dev_q;
  assign device_status_field = stat_q;
  assign watchdog_fail_field = wdCnt_q;
  assign failureFlag     = fFail_q;
  assign thermalFlag     = fTherm_q;
  assign main_supply_undervoltage_flag = fUv_q;
  assign undervoltage_failsafe_flag    = fUvFs_q;
  assign main_supply_overvoltage_flag  = fOv_q;
  assign main_supply_short_flag        = fSc_q;
endmodule // sbcrm_core

/* File: sim/sbcrm_chk.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module sbcrm_chk #(
  parameter int RESET_DELAY = 4
) (
  input wire logic       ref_clk,                  // Clock
  input wire logic       rst,                      // Reset
  input wire logic [6:0] modeState,                // Mode
  input wire logic       reset_output,             // Reset out
  input wire logic       spiIgnore,                // SPI ignored
  input wire logic       secondRegOff,             // Regulator off
  input wire logic       mainUv,                   // Undervoltage
  input wire logic       mainOv,                   // Overvoltage
  input wire logic       mainShort,                // Short
  input wire logic       overvoltage_reset_enable, // OV enable
  input wire logic       config_pin_select,        // Pin select
  input wire logic       modeBitsClear,            // Restart end
  input wire logic       wdPeriodLoad,             // Period load
  input wire logic [2:0] wdPeriodVal,              // Period value
  input wire logic       mainRegOn,                // Main regulator
  input wire logic       defaultWakeEn,            // Default wakes
  input wire logic       fail_outputs,             // Fail outputs
  input wire logic       wakeFlagsClear,           // Flag clear
  input wire logic       devMode,                  // Dev mode
  input wire logic       wakeEvent,                // Wake
  input wire logic       thermalFlag,              // Thermal flag
  input wire logic       highSideOff,              // High-side off
  input wire logic       cyclicDisable,            // Cyclic off
  input wire logic       wdLongWindow              // Long window
);
  localparam int RD_HI = RESET_DELAY + 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Restart entry and exit steps
  sequence s_enter_rst;
    $rose(modeState == 7'h10);
  endsequence
  sequence s_restart_done;
    modeBitsClear ##1 (modeState == 7'h02 && reset_output);
  endsequence
  // Mode transitions, restart and fail-safe outputs, sticky fail outputs and development mode
  a_uv_restart: assert property (modeState == 7'h02 && mainUv |=> modeState[5:4] != 2'h0)
    else $error("undervoltage did not leave normal");
  a_restart_pins: assert property (modeState == 7'h10 |->
    !reset_output && spiIgnore && secondRegOff && highSideOff)
    else $error("restart outputs wrong");
  a_restart_len: assert property (s_enter_rst |-> ##[0:RD_HI] modeBitsClear)
    else $error("restart did not end in time");
  a_restart_exit: assert property (modeBitsClear |-> s_restart_done)
    else $error("restart exit wrong");
  a_period_load: assert property (modeBitsClear |-> wdPeriodLoad && wdPeriodVal == 3'h4 &&
    modeState == 7'h10 && wdLongWindow == !devMode)
    else $error("watchdog period not forced");
  a_ov_failsafe: assert property (modeState == 7'h02 && mainOv && overvoltage_reset_enable && !config_pin_select |=> modeState == 7'h20)
    else $error("overvoltage missed fail-safe");
  a_fs_wins: assert property (modeState == 7'h02 && mainUv && mainShort |=> modeState == 7'h20)
    else $error("fail-safe lost priority");
  a_fs_entry: assert property ($rose(modeState == 7'h20) |-> !mainRegOn && defaultWakeEn &&
    fail_outputs && cyclicDisable && $past(wakeFlagsClear))
    else $error("fail-safe entry outputs wrong");
  a_fo_sticky: assert property (fail_outputs |=> fail_outputs)
    else $error("fail outputs dropped");
  a_dev_sticky: assert property (devMode |=> devMode)
    else $error("development mode dropped");
  a_wake_restart: assert property (modeState == 7'h40 && wakeEvent && !thermalFlag |=> modeState == 7'h10)
    else $error("wake did not restart");
endmodule // sbcrm_chk

bind sbcrm_core sbcrm_chk #(.RESET_DELAY(RESET_DELAY)) chk_u (
  .ref_clk, .rst, .modeState, .reset_output, .spiIgnore, .secondRegOff, .mainUv, .mainOv,
  .mainShort, .overvoltage_reset_enable, .config_pin_select, .modeBitsClear, .wdPeriodLoad,
  .wdPeriodVal, .mainRegOn, .defaultWakeEn, .fail_outputs, .wakeFlagsClear, .devMode,
  .wakeEvent, .thermalFlag, .highSideOff, .cyclicDisable, .wdLongWindow);

/* File: sim/sbcrm_mcu.sv */
// Controller model: one SPI frame after each reset release
`timescale 1ns/1ps
module sbcrm_mcu (
  input  wire logic ref_clk,      // Clock
  input  wire logic rst,          // Power-on reset
  input  wire logic reset_output, // Reset in, low active
  input  wire logic en,           // Frames allowed
  input  wire logic slow,         // Late frame
  output logic      spiCmd        // Frame, pulse
);
  logic [4:0] cnt_q;
  // Counts cycles out of reset; silent while held
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (!reset_output) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != 5'h1F) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  // Frame inside the long open window
  assign spiCmd = en && (cnt_q == (slow ? 5'h0C : 5'h03));
endmodule // sbcrm_mcu

/* File: sim/sbcrm_core_test.sv */
// Self-checking bench for the restart and fail-safe sequencer
`timescale 1ns/1ps
module sbcrm_core_test;
  typedef struct packed {
    logic [1:0] cfg;
    logic       ovEn;
    logic       pin;
    logic [6:0] mask;
    logic [6:0] mode;
    logic [8:0] flg;
  } sbcrm_row_t;
  logic ref_clk, rst, spiCmd, sleepReq, stopReq, normalReq, overvoltage_reset_enable;
  logic config_pin_select, wake_pin_measure_select, mainUv, mainOv, mainShort, supplyAboveUv;
  logic thermal_shutdown_level2, wdFail, wakeEvent, wakeFlagsPending, canActive, linActive;
  logic test_strap_pin, statusClear, reset_output, canWakeCap, linWakeCap, wakePinsMeasure;
  logic devModeDefaultsOn, devMode, failureFlag, thermalFlag, main_supply_undervoltage_flag;
  logic undervoltage_failsafe_flag, main_supply_overvoltage_flag, main_supply_short_flag;
  logic mcuEn, mcuSlow;
  logic [1:0] configSel, device_status_field, watchdog_fail_field;
  logic [6:0] modeState;
  logic [8:0] flg;
  int         mismatches, checks_done;
  sbcrm_row_t rows [9];
  assign flg = {failureFlag, undervoltage_failsafe_flag, main_supply_overvoltage_flag,
                main_supply_short_flag, main_supply_undervoltage_flag, watchdog_fail_field,
                device_status_field};
  sbcrm_core #(.RESET_DELAY(4), .FS_FILTER(8), .THERMAL_REC(16), .TEST_TIME(4)) dut_u (
    .ref_clk, .rst, .spiCmd, .sleepReq, .stopReq, .normalReq, .configSel,
    .overvoltage_reset_enable, .config_pin_select, .wake_pin_measure_select, .mainUv, .mainOv,
    .mainShort, .supplyAboveUv, .thermal_shutdown_level2, .wdFail, .wakeEvent,
    .wakeFlagsPending, .canActive, .linActive, .test_strap_pin, .statusClear, .modeState,
    .reset_output, .fail_outputs(), .mainRegOn(), .secondRegOff(), .highSideOff(), .canWakeCap,
    .linWakeCap, .defaultWakeEn(), .wakePinsMeasure, .wakeFlagsClear(), .cyclicDisable(),
    .spiIgnore(), .modeBitsClear(), .wdLongWindow(), .wdPeriodLoad(), .wdPeriodVal(),
    .devModeDefaultsOn, .devMode, .device_status_field, .watchdog_fail_field, .failureFlag,
    .thermalFlag, .main_supply_undervoltage_flag, .undervoltage_failsafe_flag,
    .main_supply_overvoltage_flag, .main_supply_short_flag);
  sbcrm_mcu mcu_u (.ref_clk, .rst, .reset_output, .en(mcuEn), .slow(mcuSlow), .spiCmd);
  // Value compare
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Event pulses: clear, sleep, wake, thermal, short, watchdog, OV, UV
  task automatic ev(input logic [7:0] m);
    @(posedge ref_clk);
    {statusClear, sleepReq, wakeEvent, thermal_shutdown_level2, mainShort, wdFail, mainOv,
     mainUv} <= m;
    @(posedge ref_clk);
    {statusClear, sleepReq, wakeEvent, thermal_shutdown_level2, mainShort, wdFail, mainOv,
     mainUv} <= 8'h00;
    #1;
  endtask
  // Bounded wait for a mode
  task automatic waitMode(input logic [6:0] m);
    int n;
    n = 0;
    while (modeState !== m && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  // Verdict
  task automatic test_done();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  // Main sequence
  initial begin
    {sleepReq, stopReq, normalReq, overvoltage_reset_enable, config_pin_select} = '0;
    {wake_pin_measure_select, mainUv, mainOv, mainShort, supplyAboveUv, wdFail} = '0;
    {thermal_shutdown_level2, wakeEvent, wakeFlagsPending, canActive, linActive} = '0;
    {statusClear, configSel, mismatches, checks_done} = '0;
    {rst, test_strap_pin, mcuEn, mcuSlow} = 4'hF;
    rows[0] = '{2'h0, 1'b0, 1'b0, 7'h01, 7'h10, 9'h011};
    rows[1] = '{2'h0, 1'b1, 1'b1, 7'h02, 7'h10, 9'h041};
    rows[2] = '{2'h0, 1'b0, 1'b1, 7'h02, 7'h02, 9'h040};
    rows[3] = '{2'h0, 1'b1, 1'b0, 7'h02, 7'h20, 9'h141};
    rows[4] = '{2'h0, 1'b0, 1'b0, 7'h04, 7'h10, 9'h005};
    rows[5] = '{2'h2, 1'b0, 1'b0, 7'h04, 7'h10, 9'h005};
    rows[6] = '{2'h1, 1'b0, 1'b0, 7'h04, 7'h20, 9'h105};
    rows[7] = '{2'h0, 1'b0, 1'b0, 7'h08, 7'h20, 9'h131};
    rows[8] = '{2'h0, 1'b0, 1'b0, 7'h09, 7'h20, 9'h131};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    test_strap_pin <= 1'b0;
    waitMode(7'h02);
    chk(devMode, 1'b0);
    mcuSlow <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      {configSel, overvoltage_reset_enable, config_pin_select} <=
        {rows[i].cfg, rows[i].ovEn, rows[i].pin};
      ev(8'h80);
      ev({1'b0, rows[i].mask});
      chk(modeState, rows[i].mode);
      if (rows[i].mode == 7'h20) begin
        waitMode(7'h40);
        ev(8'h20);
      end
      waitMode(7'h02);
      chk(flg, rows[i].flg);
    end
    // Second watchdog failure in the fourth configuration
    configSel <= 2'h3;
    ev(8'h80);
    ev(8'h04);
    chk(modeState, 7'h10);
    waitMode(7'h02);
    ev(8'h04);
    chk(modeState, 7'h20);
    waitMode(7'h40);
    ev(8'h20);
    waitMode(7'h02);
    chk(watchdog_fail_field, 2'h2);
    // Four undervoltages with supply above threshold, no frames between
    {mcuEn, supplyAboveUv, configSel} <= 4'h4;
    ev(8'h80);
    for (int k = 0; k < 4; k++) begin
      ev(8'h01);
      chk(modeState, (k == 3) ? 7'h20 : 7'h10);
      waitMode((k == 3) ? 7'h40 : 7'h02);
    end
    ev(8'h20);
    waitMode(7'h02);
    chk(undervoltage_failsafe_flag, 1'b1);
    {mcuEn, supplyAboveUv, wake_pin_measure_select} <= 3'h5;
    // Wake inside the filter time is kept
    ev(8'h08);
    ev(8'h20);
    chk(wakePinsMeasure, 1'b1);
    waitMode(7'h10);
    chk(modeState, 7'h10);
    waitMode(7'h02);
    // Thermal shutdown recovers without a wake
    ev(8'h10);
    chk(modeState, 7'h20);
    waitMode(7'h10);
    chk(modeState, 7'h10);
    waitMode(7'h02);
    chk(thermalFlag, 1'b1);
    // Sleep with pending flags, then a real sleep and wake
    canActive <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      wakeFlagsPending <= (j == 0);
      ev(8'h80);
      ev(8'h40);
      if (j == 1) begin
        chk(modeState, 7'h08);
        ev(8'h20);
      end
      waitMode(7'h10);
      chk({canWakeCap, linWakeCap}, 2'h2);
      waitMode(7'h02);
      chk(device_status_field, 2'h2);
    end
    // New power-on with the strap low gives development mode
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    waitMode(7'h02);
    chk(devMode, 1'b1);
    chk(devModeDefaultsOn, 1'b1);
    configSel <= 2'h1;
    ev(8'h04);
    chk(modeState, 7'h02);
    // Undervoltage out of stop mode also restarts
    @(posedge ref_clk) stopReq <= 1'b1;
    @(posedge ref_clk) stopReq <= 1'b0;
    #1 chk(modeState, 7'h04);
    ev(8'h01);
    chk(modeState, 7'h10);
    waitMode(7'h02);
    chk(devMode, 1'b1);
    test_done();
  end
endmodule // sbcrm_core_test
